// File: rtl/bst_tap.sv
// Boundary-scan test access port with boundary register and pin muxing
//
// Contract
// - Exactly one register between serial in/out
// - Three-bit instruction register, captures 001
// - Code 000 selects boundary register, external test
// - Code 001 selects boundary register, sample only
// - Code 101 selects identification register
// - Identification register: 32 bits, fixed code
// - Codes 110 and 111 select bypass
// - Bypass is one flip-flop delay
// - Code 010 floats all outputs
// - Controller advanced by test clock, steered by mode
// - Every primary pin has a chained cell
// - Four test pins plus optional active-low reset
// - Interface select cell reads constant low
`timescale 1ns/100ps
`default_nettype none
`include "bst_defs.svh"

module bst_tap
  import bst_pkg::*;
#(
  parameter int                     NUM_IN  = 8,            // Primary input pins
  parameter int                     NUM_OUT = 8,            // Primary output pins
  parameter logic [`BST_ID_W-1:0]   ID_CODE = 32'h0000_0001 // Arbitrary value, bit 0 set
) (
  input  wire logic               test_clock,          // Tester clock, link domain
  input  wire logic               test_mode_sel,       // Tester mode select
  input  wire logic               test_data_in,        // Serial data from tester
  input  wire logic               test_reset_n,        // Optional test reset, tie high if unused
  output logic                    test_data_out,       // Serial data to tester
  output logic                    test_data_out_oe_n,  // Low while driving serial out
  input  wire logic               clock,               // Core clock
  input  wire logic               arst_n,              // Core reset
  input  wire logic [NUM_IN-1:0]  pin_in,              // Primary input pins
  output logic      [NUM_IN-1:0]  core_in,             // Synchronised inputs to core
  input  wire logic [NUM_OUT-1:0] core_out,            // Core output data
  input  wire logic [NUM_OUT-1:0] core_oe_n,           // Core output enables, low drives
  output logic      [NUM_OUT-1:0] pin_out,             // Primary output pin data
  output logic      [NUM_OUT-1:0] pin_oe_n             // Primary output enables, low drives
);

  // ****************************************************************
  // Sizes and elaboration checks
  // ****************************************************************
  localparam int BSR_LEN = 1 + NUM_IN + 2 * NUM_OUT;
  localparam int CAP_W   = NUM_IN + 2 * NUM_OUT;

  // Identification code must have its marker bit set
  generate
    if (NUM_IN < 1 || NUM_OUT < 1 || ID_CODE[0] != 1'b1) begin : g_bad_params
      $error("bst_tap: pin counts must be positive and ID_CODE bit 0 must be 1");
    end
  endgenerate

  // Which register a given instruction puts in the serial path
  function automatic bst_path_e path_of(input logic [`BST_IR_W-1:0] ins);
    bst_path_e p;
    p = PATH_BYPASS;
    unique case (ins)
      `BST_INS_EXTEST,
      `BST_INS_SAMPLE: p = PATH_BSR;
      `BST_INS_IDCODE: p = PATH_IDENT;
      default:         p = PATH_BYPASS;    // unused and high-z codes too
    endcase
    return p;
  endfunction : path_of

  // ****************************************************************
  // Test clock domain: reset and controller
  // ****************************************************************
  logic       tap_rst_n;
  bst_state_e state_r;
  bst_state_e state_nxt;

  // Either reset clears the test logic; no clock needed for it
  assign tap_rst_n = test_reset_n & arst_n;

  // Controller state, moves only on test clock edges
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_r <= ST_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Standard sixteen-state sequence, steered by mode select
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_TLR:  state_nxt = test_mode_sel ? ST_TLR  : ST_RTI;
      ST_RTI:  state_nxt = test_mode_sel ? ST_SDRS : ST_RTI;
      ST_SDRS: state_nxt = test_mode_sel ? ST_SIRS : ST_CDR;
      ST_CDR:  state_nxt = test_mode_sel ? ST_E1DR : ST_SDR;
      ST_SDR:  state_nxt = test_mode_sel ? ST_E1DR : ST_SDR;
      ST_E1DR: state_nxt = test_mode_sel ? ST_UDR  : ST_PDR;
      ST_PDR:  state_nxt = test_mode_sel ? ST_E2DR : ST_PDR;
      ST_E2DR: state_nxt = test_mode_sel ? ST_UDR  : ST_SDR;
      ST_UDR:  state_nxt = test_mode_sel ? ST_SDRS : ST_RTI;
      ST_SIRS: state_nxt = test_mode_sel ? ST_TLR  : ST_CIR;
      ST_CIR:  state_nxt = test_mode_sel ? ST_E1IR : ST_SIR;
      ST_SIR:  state_nxt = test_mode_sel ? ST_E1IR : ST_SIR;
      ST_E1IR: state_nxt = test_mode_sel ? ST_UIR  : ST_PIR;
      ST_PIR:  state_nxt = test_mode_sel ? ST_E2IR : ST_PIR;
      ST_E2IR: state_nxt = test_mode_sel ? ST_UIR  : ST_SIR;
      ST_UIR:  state_nxt = test_mode_sel ? ST_SDRS : ST_RTI;
    endcase
  end

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  logic [`BST_IR_W-1:0] ir_shift_r;
  logic [`BST_IR_W-1:0] ir_r;
  bst_path_e            path;

  // Shift stage: fixed pattern on capture, then shifts toward serial out
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_shift_r <= `BST_IR_CAPTURE;
    end else if (state_r == ST_CIR) begin
      ir_shift_r <= `BST_IR_CAPTURE;
    end else if (state_r == ST_SIR) begin
      ir_shift_r <= {test_data_in, ir_shift_r[`BST_IR_W-1:1]};
    end
  end

  // Current instruction; changes only on update or in test-logic reset so pins never glitch mid-shift
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ir_r <= `BST_IR_RESET;
    end else if (state_r == ST_TLR) begin
      ir_r <= `BST_IR_RESET;
    end else if (state_r == ST_UIR) begin
      ir_r <= ir_shift_r;
    end
  end

  assign path = path_of(ir_r);

  // ****************************************************************
  // Pin sampling into the test clock domain
  // ****************************************************************
  logic [CAP_W-1:0]   cap_meta_r;
  logic [CAP_W-1:0]   cap_sync_r;
  logic [BSR_LEN-1:0] bsr_cap;

  // Pins and core signals are foreign to the test clock: two flops first
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      cap_meta_r <= '0;
      cap_sync_r <= '0;
    end else begin
      cap_meta_r <= {~core_oe_n, core_out, pin_in};
      cap_sync_r <= cap_meta_r;
    end
  end

  // Chain order from serial out: select cell, inputs, output data, enables
  assign bsr_cap = {cap_sync_r, `BST_IFSEL_VALUE};

  // ****************************************************************
  // Data registers
  // ****************************************************************
  logic                 bypass_r;
  logic [`BST_ID_W-1:0] id_shift_r;
  logic [BSR_LEN-1:0]   bsr_shift_r;
  logic [BSR_LEN-1:0]   bsr_upd_r;
  logic                 upd_tgl_r;

  // Bypass: one stage from serial in to serial out
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bypass_r <= `BST_BYPASS_CAP;
    end else if (path == PATH_BYPASS && state_r == ST_CDR) begin
      bypass_r <= `BST_BYPASS_CAP;
    end else if (path == PATH_BYPASS && state_r == ST_SDR) begin
      bypass_r <= test_data_in;
    end
  end

  // Identification: hard-wired code loaded on capture
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      id_shift_r <= '0;
    end else if (path == PATH_IDENT && state_r == ST_CDR) begin
      id_shift_r <= ID_CODE;
    end else if (path == PATH_IDENT && state_r == ST_SDR) begin
      id_shift_r <= {test_data_in, id_shift_r[`BST_ID_W-1:1]};
    end
  end

  // Boundary shift chain: capture pins, then shift
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bsr_shift_r <= '0;
    end else if (path == PATH_BSR && state_r == ST_CDR) begin
      bsr_shift_r <= bsr_cap;
    end else if (path == PATH_BSR && state_r == ST_SDR) begin
      bsr_shift_r <= {test_data_in, bsr_shift_r[BSR_LEN-1:1]};
    end
  end

  // Boundary update latch; a toggle tells the core domain it changed
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      bsr_upd_r <= '0;
      upd_tgl_r <= 1'b0;
    end else if (path == PATH_BSR && state_r == ST_UDR) begin
      bsr_upd_r <= {bsr_shift_r[BSR_LEN-1:1], `BST_IFSEL_VALUE};
      upd_tgl_r <= ~upd_tgl_r;
    end
  end

  // ****************************************************************
  // Serial output, changes on the falling test clock edge
  // ****************************************************************
  logic tdo_nxt;
  logic tdo_en_nxt;

  // Only the selected register reaches serial out
  always_comb begin
    tdo_nxt    = 1'b0;
    tdo_en_nxt = 1'b0;
    if (state_r == ST_SIR) begin
      tdo_nxt    = ir_shift_r[0];
      tdo_en_nxt = 1'b1;
    end else if (state_r == ST_SDR) begin
      tdo_en_nxt = 1'b1;
      unique case (path)
        PATH_BSR:   tdo_nxt = bsr_shift_r[0];
        PATH_IDENT: tdo_nxt = id_shift_r[0];
        default:    tdo_nxt = bypass_r;
      endcase
    end
  end

  // Falling edge gives the tester half a period of setup
  always_ff @(negedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      test_data_out      <= 1'b0;
      test_data_out_oe_n <= 1'b1;
    end else begin
      test_data_out      <= tdo_nxt;
      test_data_out_oe_n <= ~tdo_en_nxt;
    end
  end

  // ****************************************************************
  // Mode levels handed to the core clock domain
  // ****************************************************************
  logic ext_mode_r;
  logic highz_mode_r;

  // Set with the instruction itself, so a tester that stops its clock still reaches the pins
  always_ff @(posedge test_clock or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      ext_mode_r   <= 1'b0;
      highz_mode_r <= 1'b0;
    end else if (state_r == ST_UIR || state_r == ST_TLR) begin
      ext_mode_r   <= (state_r == ST_UIR) && (ir_shift_r == `BST_INS_EXTEST);
      highz_mode_r <= (state_r == ST_UIR) && (ir_shift_r == `BST_INS_HIGHZ);
    end
  end

  // ****************************************************************
  // Core clock domain
  // ****************************************************************
  logic [1:0]         ext_sync_r;
  logic [1:0]         highz_sync_r;
  logic [2:0]         tgl_sync_r;
  logic [NUM_IN-1:0]  pin_meta_r;
  logic [NUM_IN-1:0]  pin_sync_r;
  logic [BSR_LEN-1:0] upd_hold_r;
  logic [NUM_OUT-1:0] upd_data;
  logic [NUM_OUT-1:0] upd_drive;

  // Two flops per level; third toggle stage only feeds the edge compare
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ext_sync_r   <= '0;
      highz_sync_r <= '0;
      tgl_sync_r   <= '0;
    end else begin
      ext_sync_r   <= {ext_sync_r[0], ext_mode_r};
      highz_sync_r <= {highz_sync_r[0], highz_mode_r};
      tgl_sync_r   <= {tgl_sync_r[1:0], upd_tgl_r};
    end
  end

  // Update latch is stable between toggles, so copying it on the edge is safe
  // Limitation: updates closer than about three core clocks may be merged
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upd_hold_r <= '0;
    end else if (tgl_sync_r[2] != tgl_sync_r[1]) begin
      upd_hold_r <= bsr_upd_r;
    end
  end

  assign upd_data  = upd_hold_r[NUM_IN+1 +: NUM_OUT];
  assign upd_drive = upd_hold_r[NUM_IN+1+NUM_OUT +: NUM_OUT];

  // Input pins reach the core through three flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      core_in    <= '0;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
      core_in    <= pin_sync_r;
    end
  end

  // Output pins: high-z wins, then external test, else core drives
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end else if (highz_sync_r[1]) begin
      pin_out  <= core_out;
      pin_oe_n <= '1;
    end else if (ext_sync_r[1]) begin
      pin_out  <= upd_data;
      pin_oe_n <= ~upd_drive;
    end else begin
      pin_out  <= core_out;
      pin_oe_n <= core_oe_n;
    end
  end

endmodule : bst_tap
`default_nettype wire

// File: rtl/bst_defs.svh
// Constants for the boundary-scan test access port
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// ****************************************************************
// Instruction register
// ****************************************************************
`define BST_IR_W          3
`define BST_IR_CAPTURE    3'h1
`define BST_INS_EXTEST    3'h0
`define BST_INS_SAMPLE    3'h1
`define BST_INS_HIGHZ     3'h2
`define BST_INS_IDCODE    3'h5
`define BST_INS_BYPASS    3'h6
`define BST_INS_BYPASS2   3'h7
`define BST_IR_RESET      `BST_INS_IDCODE

// ****************************************************************
// Data registers
// ****************************************************************
`define BST_ID_W          32
`define BST_BYPASS_CAP    1'b0
`define BST_IFSEL_VALUE   1'b0
`define BST_SYNC_STAGES   2

`endif

// File: rtl/bst_pkg.sv
// Types for the boundary-scan test access port
package bst_pkg;

  // Sixteen controller states, binary codes
  typedef enum logic [3:0] {
    ST_TLR  = 4'h0, ST_RTI  = 4'h1, ST_SDRS = 4'h2, ST_CDR  = 4'h3,
    ST_SDR  = 4'h4, ST_E1DR = 4'h5, ST_PDR  = 4'h6, ST_E2DR = 4'h7,
    ST_UDR  = 4'h8, ST_SIRS = 4'h9, ST_CIR  = 4'hA, ST_SIR  = 4'hB,
    ST_E1IR = 4'hC, ST_PIR  = 4'hD, ST_E2IR = 4'hE, ST_UIR  = 4'hF
  } bst_state_e;

  // Register placed between serial input and output
  typedef enum logic [1:0] {
    PATH_BYPASS = 2'h0,
    PATH_BSR    = 2'h1,
    PATH_IDENT  = 2'h2
  } bst_path_e;

endpackage : bst_pkg

// File: dv/bst_tap_chk.sv
// Concurrent checks on the test access port pins
`timescale 1ns/100ps
`default_nettype none
`include "bst_defs.svh"

module bst_tap_chk
  import bst_pkg::*;
#(
  parameter int NUM_IN  = 8, // Input pins
  parameter int NUM_OUT = 8  // Output pins
) (
  input wire logic               test_clock,         // Tester clock
  input wire logic               test_mode_sel,      // Mode select
  input wire logic               test_data_in,       // Serial in
  input wire logic               test_reset_n,       // Test reset
  input wire logic               test_data_out,      // Serial out
  input wire logic               test_data_out_oe_n, // Serial out enable
  input wire logic               clock,              // Core clock
  input wire logic               arst_n,             // Core reset
  input wire logic [NUM_IN-1:0]  pin_in,             // Input pins
  input wire logic [NUM_IN-1:0]  core_in,            // To core
  input wire logic [NUM_OUT-1:0] core_out,           // From core
  input wire logic [NUM_OUT-1:0] core_oe_n,          // Core enables
  input wire logic [NUM_OUT-1:0] pin_out,            // Pin data
  input wire logic [NUM_OUT-1:0] pin_oe_n            // Pin enables
);
  // ****************************************************************
  // Controller model and checks
  // ****************************************************************
  bst_state_e st_r;    // Modelled controller state
  bst_state_e st_nxt;  // Its next value
  logic [2:0] ir_sh_r; // Instruction shift stage
  logic [2:0] ir_r;    // Instruction in force
  logic [2:0] md_r;    // Instruction seen by core clock
  logic [2:0] cnt_r;   // Core clocks since md_r changed, saturates

  // Standard walk steered by mode select
  always_comb begin
    case (st_r)
      ST_TLR:                st_nxt = test_mode_sel ? ST_TLR  : ST_RTI;
      ST_RTI, ST_UDR, ST_UIR: st_nxt = test_mode_sel ? ST_SDRS : ST_RTI;
      ST_SDRS:               st_nxt = test_mode_sel ? ST_SIRS : ST_CDR;
      ST_SIRS:               st_nxt = test_mode_sel ? ST_TLR  : ST_CIR;
      ST_CDR, ST_SDR:        st_nxt = test_mode_sel ? ST_E1DR : ST_SDR;
      ST_E1DR:               st_nxt = test_mode_sel ? ST_UDR  : ST_PDR;
      ST_PDR:                st_nxt = test_mode_sel ? ST_E2DR : ST_PDR;
      ST_E2DR:               st_nxt = test_mode_sel ? ST_UDR  : ST_SDR;
      ST_CIR, ST_SIR:        st_nxt = test_mode_sel ? ST_E1IR : ST_SIR;
      ST_E1IR:               st_nxt = test_mode_sel ? ST_UIR  : ST_PIR;
      ST_PIR:                st_nxt = test_mode_sel ? ST_E2IR : ST_PIR;
      default:               st_nxt = test_mode_sel ? ST_UIR  : ST_SIR;
    endcase
  end

  // Either reset puts the model back to ident
  always_ff @(posedge test_clock or negedge arst_n or negedge test_reset_n) begin
    if (!arst_n || !test_reset_n) begin
      st_r    <= ST_TLR;
      ir_sh_r <= 3'h0;
      ir_r    <= `BST_IR_RESET;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_SIR) ir_sh_r <= {test_data_in, ir_sh_r[2:1]};
      if (st_r == ST_UIR) ir_r <= ir_sh_r;
      else if (st_r == ST_TLR) ir_r <= `BST_IR_RESET;
    end
  end

  // Settling count; pins lag the mode by a few core clocks
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      md_r  <= `BST_IR_RESET;
      cnt_r <= 3'h0;
    end else begin
      md_r <= ir_r;
      if (ir_r != md_r) cnt_r <= 3'h0;
      else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
    end
  end

  property p_exit_shift;
    @(posedge test_clock) disable iff (!arst_n || !test_reset_n)
      test_mode_sel |=> test_data_out_oe_n;
  endproperty
  a_exit_shift: assert property (p_exit_shift) else $error("out enabled off shift");
  property p_quiet;
    @(posedge test_clock) disable iff (!arst_n || !test_reset_n)
      test_data_out_oe_n |-> !test_data_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("serial out not quiet");
  property p_shift_on;
    @(posedge test_clock) disable iff (!arst_n || !test_reset_n)
      (st_r == ST_SIR || st_r == ST_SDR) |-> !test_data_out_oe_n;
  endproperty
  a_shift_on: assert property (p_shift_on) else $error("serial out off in shift");
  property p_ir_cap;
    @(posedge test_clock) disable iff (!arst_n || !test_reset_n)
      st_r == ST_SIR && $past(st_r) == ST_CIR |-> test_data_out ##1 !test_data_out;
  endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("bad instruction capture");
  property p_bypass;
    @(posedge test_clock) disable iff (!arst_n || !test_reset_n)
      st_r == ST_SDR && ir_r[2:1] == 2'b11
        |-> test_data_out == ($past(st_r) == ST_SDR && $past(test_data_in));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass stage wrong");
  property p_highz;
    @(posedge clock) disable iff (!arst_n)
      cnt_r == 3'h7 && md_r == `BST_INS_HIGHZ |-> &pin_oe_n;
  endproperty
  a_highz: assert property (p_highz) else $error("pin driven in high-z");
  property p_normal;
    @(posedge clock) disable iff (!arst_n)
      cnt_r == 3'h7 && md_r != `BST_INS_EXTEST && md_r != `BST_INS_HIGHZ
        |-> pin_out == $past(core_out) && pin_oe_n == $past(core_oe_n);
  endproperty
  a_normal: assert property (p_normal) else $error("core path disturbed");
  property p_core_in;
    @(posedge clock) disable iff (!arst_n)
      cnt_r == 3'h7 |-> core_in == $past(pin_in, 3);
  endproperty
  a_core_in: assert property (p_core_in) else $error("input path wrong");
endmodule : bst_tap_chk

bind bst_tap bst_tap_chk #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) bst_tap_chk_inst (
  .test_clock, .test_mode_sel, .test_data_in, .test_reset_n, .test_data_out,
  .test_data_out_oe_n, .clock, .arst_n, .pin_in, .core_in, .core_out, .core_oe_n,
  .pin_out, .pin_oe_n
);
`default_nettype wire

// File: dv/bst_tester.sv
// Behavioural boundary-scan tester driving the test port
`timescale 1ns/100ps
`default_nettype none

module bst_tester (
  output logic        test_clock,         // Runs only inside transfers
  output logic        test_mode_sel,      // Mode select
  output logic        test_data_in,       // Serial data to device
  output logic        test_reset_n,       // Test reset
  input  wire logic   test_data_out,      // Serial data from device
  input  wire logic   test_data_out_oe_n, // Device drive enable
  output logic [31:0] scan_out,           // Bits read by last scan
  output logic        done                // Pulses when a scan is to be judged
);
  // ****************************************************************
  // Clocking tasks
  // ****************************************************************
  logic last; // Serial out seen at the last rise

  initial begin
    test_clock    = 1'b0;
    test_mode_sel = 1'b1;
    test_data_in  = 1'b0;
    test_reset_n  = 1'b0;
    scan_out      = 32'h0000_0000;
    done          = 1'b0;
  end

  // One test clock period; serial out read at the rise
  task automatic tick(input logic ms, input logic di);
    test_mode_sel = ms;
    test_data_in  = di;
    #15;
    last       = test_data_out_oe_n ? ~last : test_data_out; // Released line carries no data
    test_clock = 1'b1;
    #15 test_clock = 1'b0;
  endtask : tick

  // Idle data line toggles so a stale level is never read as valid
  task automatic reset_tap();
    test_reset_n = 1'b0;
    tick(1'b1, ~test_data_in);
    test_reset_n = 1'b1;
    repeat (5) tick(1'b1, ~test_data_in);
    tick(1'b0, ~test_data_in);
  endtask : reset_tap

  // From idle: capture, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, input logic chk);
    int i;
    scan_out = 32'h0000_0000;
    tick(1'b1, ~test_data_in);
    if (ir) tick(1'b1, ~test_data_in);
    tick(1'b0, ~test_data_in);
    tick(1'b0, ~test_data_in);
    for (i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      scan_out[i] = last;
    end
    tick(1'b1, ~test_data_in);
    tick(1'b0, ~test_data_in);
    done = chk;
    #1 done = 1'b0;
  endtask : scan
endmodule : bst_tester
`default_nettype wire

// File: dv/boundary_scan_test_access_port_test.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/100ps
`default_nettype none
`include "bst_defs.svh"

module boundary_scan_test_access_port_test;
  // ****************************************************************
  // Stimulus, watcher and verdict
  // ****************************************************************
  localparam logic [31:0] ID = 32'h00C3_5A1D; // Arbitrary value, bit 0 set
  logic        clock, arst_n, test_clock, test_mode_sel, test_data_in, test_reset_n;
  logic        test_data_out, test_data_out_oe_n, pin_ev, done;
  logic [7:0]  pin_in, core_in, core_out, core_oe_n, pin_out, pin_oe_n;
  logic [31:0] exp_q[$];
  logic [31:0] got, v, scan_out;
  logic [2:0]  code;
  logic [2:0]  codes [6] = '{3'h5, 3'h6, 3'h7, 3'h2, 3'h3, 3'h4};
  int          errors = 0, comparisons = 0, seed = 85193, i;

  bst_tap #(.NUM_IN(8), .NUM_OUT(8), .ID_CODE(ID)) bst_tap_inst (
    .test_clock, .test_mode_sel, .test_data_in, .test_reset_n, .test_data_out,
    .test_data_out_oe_n, .clock, .arst_n, .pin_in, .core_in, .core_out, .core_oe_n,
    .pin_out, .pin_oe_n);
  bst_tester bst_tester_inst (.test_clock, .test_mode_sel, .test_data_in, .test_reset_n,
    .test_data_out, .test_data_out_oe_n, .scan_out, .done);

  always #20 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic note(input logic [31:0] e);
    exp_q.push_back(e);
  endtask : note

  // Undriven pin data is masked, its level means nothing
  function automatic logic [31:0] norm();
    return {8'h00, pin_in, core_oe_n, core_out & ~core_oe_n};
  endfunction : norm

  task automatic stir();
    @(negedge clock);
    {pin_in, core_out, core_oe_n} = 24'($random(seed));
  endtask : stir

  // Enough clocks for the syncs and the mode crossing
  task automatic pins();
    repeat (8) @(negedge clock);
    pin_ev = 1'b1;
    #1 pin_ev = 1'b0;
  endtask : pins

  // Each result meets the oldest note
  always @(posedge done or posedge pin_ev) begin
    got = pin_ev ? {8'h00, core_in, pin_oe_n, pin_out & ~pin_oe_n} : scan_out;
    check(got, exp_q.pop_front());
  end

  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // Whole run is some twelve microseconds; about sixteen times that means a hang
  initial begin
    #200000;
    errors++;
    complete_run();
  end

  initial begin
    {clock, arst_n, pin_ev, pin_in, core_out, core_oe_n} = 27'h000_00FF;
    repeat (20) @(posedge clock);
    @(negedge clock) arst_n = 1'b1;
    bst_tester_inst.reset_tap();
    note(ID);
    bst_tester_inst.scan(1'b0, 32, 32'h0000_0000, 1'b1);
    stir();
    note(norm());
    pins();
    for (i = 0; i < 6; i++) begin
      code = codes[i];
      v = $random(seed);
      note(32'h0000_0001);
      bst_tester_inst.scan(1'b1, 3, {29'h0, code}, 1'b1);
      if (code == `BST_INS_IDCODE) note(ID);
      else note({16'h0000, v[14:0], 1'b0});
      bst_tester_inst.scan(1'b0, (code == `BST_INS_IDCODE) ? 32 : 16, v, 1'b1);
      if (code == `BST_INS_HIGHZ) note({8'h00, pin_in, 16'hFF00});
      if (code == `BST_INS_HIGHZ) pins();
    end
    stir();
    bst_tester_inst.scan(1'b1, 3, {29'h0, `BST_INS_SAMPLE}, 1'b0);
    v = $random(seed);
    note({7'h00, ~core_oe_n, core_out, pin_in, 1'b0});
    bst_tester_inst.scan(1'b0, 25, v, 1'b1);
    note(norm());
    pins();
    bst_tester_inst.scan(1'b1, 3, {29'h0, `BST_INS_EXTEST}, 1'b0);
    v = $random(seed);
    bst_tester_inst.scan(1'b0, 25, v, 1'b0);
    note({8'h00, pin_in, ~v[24:17], v[16:9] & v[24:17]});
    pins();
    bst_tester_inst.reset_tap();
    note(norm());
    pins();
    check(32'(exp_q.size()), 32'h0000_0000);
    complete_run();
  end
endmodule : boundary_scan_test_access_port_test
`default_nettype wire
